// ---- ddspc_core.sv ----
// Synthesizer core: phase accumulator, cosine amplitude, clock-mode control
// and serial-port pin duties. Assumes all pins come from outside the clock
// domain; reference and crystal clocks are modelled as status levels.
// What this block does
// - Accumulate phase in a 32-bit accumulator
// - Tuning word is unsigned, aliasing above half
// - Zero tuning word holds current phase
// - Clear-phase bit forces accumulator output zero
// - Clear active at power up until update
// - Keep top 19 phase bits for lookup
// - Cosine of phase feeds 10-bit converter
// - Mode pin high enables crystal oscillator
// - Mode pin low uses external reference
// - Buffer-disable bit stops system clock in crystal mode only
// - Buffer disable keeps crystal running
// - Oscillator-output bit enables output buffer in crystal mode only
// - Multiplier values 4 to 20 multiply
// - Other values bypass and power down multiplier
// - Multiplier independent of buffer-disable bit
// - Abort pin resets serial port immediately
// - Reset pin restores initial state except lock timer and sync-edge tracker
// - Chip select low enables serial traffic
// - Three-wire uses separate output pin
// - Keying pin sets ramp direction, sync-sampled
// - Sync input rising edge is flagged; sync clock stays free-running
// - Update strobe rising edge loads active registers
// - System clock equals reference times factor
module ddspc_core
	import ddspc_pkg::*;
#(
	parameter int LOCK_CYC = PLL_LOCK_CYC
) (
	input  wire logic              i_mclk,            // Core clock, 40 MHz
	input  wire logic              i_resetn,          // Synchronous reset, active low
	input  wire logic              i_hw_reset,        // Device reset pin, active high
	input  wire logic [ACC_W-1:0]  i_freq_tuning_word, // Buffered tuning word
	input  wire logic              i_clear_phase,     // Buffered clear-phase bit
	input  wire logic [MULT_W-1:0] i_mult,            // Buffered multiplier field
	input  wire logic              i_buf_disable,     // Buffered oscillator buffer gate
	input  wire logic              i_osc_out_en,      // Buffered crystal-out enable
	input  wire logic              i_io_update,       // Register update strobe pin
	input  wire logic              i_osc_mode_select, // Oscillator mode pin
	input  wire logic              i_serial_port_abort, // Serial abort pin
	input  wire logic              i_csn,             // Serial chip select, active low
	input  wire logic              i_sclk,            // Serial clock pin
	input  wire logic              i_sdio_in,         // Data pin input level
	input  wire logic              i_three_wire,      // Data pin input-only mode
	input  wire logic              i_read_bit,        // Read data from serial logic
	input  wire logic              i_read_active,     // Serial logic in read phase
	input  wire logic              i_keying_en,       // Shaped keying enabled
	input  wire logic              i_keying_direction_in, // Keying direction pin
	input  wire logic              i_sync_in,         // Sync input pin
	output logic [AMP_W-1:0]       o_amp,             // Converter code
	output logic [PHASE_W-1:0]     o_phase,           // Truncated phase
	output logic                   o_osc_enable,      // Crystal oscillator running
	output logic                   o_osc_buf_enable,  // Oscillator buffer on
	output logic                   o_crystal_out_en,  // Crystal-out pin buffer on
	output ddspc_clk_mode_t        o_clk_mode,        // System clock source
	output logic [MULT_W-1:0]      o_mult_factor,     // Active multiplier, 1 in bypass
	output logic                   o_pll_powerdown,   // Multiplier shut down
	output logic                   o_pll_locking,     // Lock wait running
	output logic                   o_serial_reset,    // Serial controller reset
	output logic                   o_serial_enable,   // Serial traffic accepted
	output logic                   o_sclk_rise,       // Serial clock rising edge
	output logic                   o_sdi,             // Serial data in, synced
	output logic                   o_sdio_out,        // Data pin output value
	output logic                   o_sdio_oen,        // Data pin enable, low drives
	output logic                   o_serial_out_pin,  // Dedicated serial output
	output logic                   o_sync_clk,        // Sync clock output
	output logic                   o_keying_dir,      // Keying ramp direction
	output logic                   o_sync_edge        // Sync input rising edge
);
	localparam int NP = 8;

	typedef struct packed {
		logic [NP-1:0]     s1;
		logic [NP-1:0]     s2;
		logic              upd_d;
		logic              sclk_d;
		logic              sync_d;
		logic              clr_active;
		logic [ACC_W-1:0]  freq_tuning_word;
		logic [MULT_W-1:0] mult;
		logic              buf_dis;
		logic              osc_out;
		logic [ACC_W-1:0]  acc;
		logic [2:0]        sdiv;
		logic              sync_clk;
		logic              keying_dir;
		logic              sync_edge;
		logic              sclk_rise;
		logic              sdi;
		logic              serial_reset;
		logic              serial_enable;
		logic              sdio_out;
		logic              sdio_oen;
		logic              so_pin;
		logic              osc_en;
		logic              osc_buf;
		logic              xtal_out;
		ddspc_clk_mode_t   clk_mode;
		logic [MULT_W-1:0] factor;
		logic              pll_pd;
		logic [PHASE_W-1:0] phase;
		logic [AMP_W-1:0]  amp;
	} ddspc_core_state_t;

	ddspc_core_state_t state;
	ddspc_core_state_t next_state;
	ddspc_phase_if     ph ();
	logic              locking;
	logic [NP-1:0]     pins;

	assign pins = {i_hw_reset, i_io_update, i_osc_mode_select, i_serial_port_abort,
		i_csn, i_sclk, i_sdio_in, i_keying_direction_in};
	assign ph.phase = state.acc[ACC_W-1 -: PHASE_W];

	ddspc_cos u_cos (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.p        (ph)
	);

	ddspc_lock #(.LOCK_CYC(LOCK_CYC)) u_lock (
		.i_mclk    (i_mclk),
		.i_resetn  (i_resetn),
		.i_mult    (state.mult),
		.o_locking (locking)
	);

	// Synced pin levels
	logic hw_rst, upd, mode, abort, csn, sclk, sdi, keyin, sync_lvl, in_range;
	always_comb begin
		{hw_rst, upd, mode, abort, csn, sclk, sdi, keyin} = state.s2;
		sync_lvl = state.sync_d;
		in_range = (state.mult >= MULT_MIN) && (state.mult <= MULT_MAX);
	end

	always_comb begin
		next_state = state;
		next_state.s1 = pins;
		next_state.s2 = state.s1;
		next_state.upd_d = upd;
		next_state.sclk_d = sclk;
		// Raw sync pin is only read through its own synchroniser below
		next_state.sync_d = state.sync_d;
		// Update strobe edge moves buffered values into active copies
		if (upd && !state.upd_d) begin
			next_state.freq_tuning_word        = i_freq_tuning_word;
			next_state.clr_active = i_clear_phase;
			next_state.mult       = i_mult;
			next_state.buf_dis    = i_buf_disable;
			next_state.osc_out    = i_osc_out_en;
		end
		// Unsigned add, natural wrap; zero word holds phase
		if (state.clr_active) begin
			next_state.acc = ACC_ZERO;
		end else begin
			next_state.acc = state.acc + state.freq_tuning_word;
		end
		next_state.phase = ph.phase;
		next_state.amp   = ph.amp;
		// Clock generation
		next_state.osc_en   = mode;
		next_state.osc_buf  = mode && !state.buf_dis;
		next_state.xtal_out = mode && state.osc_out;
		next_state.pll_pd   = !in_range;
		next_state.factor   = in_range ? state.mult : MULT_W'(1);
		if (mode && state.buf_dis) begin
			next_state.clk_mode = DDSPC_CLK_OFF;
		end else if (in_range) begin
			next_state.clk_mode = DDSPC_CLK_MULT;
		end else begin
			next_state.clk_mode = DDSPC_CLK_REF;
		end
		// Serial pin duties
		next_state.serial_reset  = abort;
		next_state.serial_enable = !abort && !csn;
		next_state.sclk_rise = sclk && !state.sclk_d && !abort && !csn;
		next_state.sdi       = sdi;
		next_state.sdio_oen  = !(!i_three_wire && i_read_active && !csn && !abort);
		next_state.sdio_out  = i_read_bit;
		next_state.so_pin    = i_three_wire ? i_read_bit : 1'b0;
		// Sync clock: core clock divided by eight, keying sampled on its rise
		next_state.sdiv = state.sdiv + SYNC_DIV_ONE;
		if (state.sdiv == SYNC_DIV_LAST) begin
			next_state.sync_clk = 1'b1;
			next_state.keying_dir = keyin;
		end else if (state.sdiv == ~SYNC_DIV_ZERO) begin
			next_state.sync_clk = 1'b0;
		end
		// Disabled keying drops direction at once, not at next sync rise
		if (!i_keying_en) begin
			next_state.keying_dir = 1'b0;
		end
		next_state.sync_edge = 1'b0;
		if (!i_resetn || hw_rst) begin
			next_state = '0;
			next_state.s1 = pins;
			next_state.s2 = state.s1;
			next_state.clr_active = 1'b1;
			next_state.sdio_oen = 1'b1;
			next_state.serial_reset = 1'b1;
			next_state.factor = MULT_W'(1);
			next_state.pll_pd = 1'b1;
			next_state.clk_mode = DDSPC_CLK_REF;
			next_state.amp = AMP_MID;
			if (!i_resetn) begin
				next_state.s1 = '0;
				next_state.s2 = '0;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		state <= next_state;
	end

	// Sync input edge tracked separately through its own three stages
	logic [2:0] sync_sh;
	logic       sync_rise;
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			sync_sh   <= 3'h0;
			sync_rise <= 1'b0;
		end else begin
			sync_sh   <= {sync_sh[1:0], i_sync_in};
			sync_rise <= sync_sh[1] && !sync_sh[2];
		end
	end

	logic locking_q;
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			locking_q <= 1'b0;
		end else begin
			locking_q <= locking;
		end
	end

	assign o_amp            = state.amp;
	assign o_phase          = state.phase;
	assign o_osc_enable     = state.osc_en;
	assign o_osc_buf_enable = state.osc_buf;
	assign o_crystal_out_en = state.xtal_out;
	assign o_clk_mode       = state.clk_mode;
	assign o_mult_factor    = state.factor;
	assign o_pll_powerdown  = state.pll_pd;
	assign o_pll_locking    = locking_q;
	assign o_serial_reset   = state.serial_reset;
	assign o_serial_enable  = state.serial_enable;
	assign o_sclk_rise      = state.sclk_rise;
	assign o_sdi            = state.sdi;
	assign o_sdio_out       = state.sdio_out;
	assign o_sdio_oen       = state.sdio_oen;
	assign o_serial_out_pin = state.so_pin;
	assign o_sync_clk       = state.sync_clk;
	assign o_keying_dir     = state.keying_dir;
	assign o_sync_edge      = sync_rise;
endmodule : ddspc_core

// ---- ddspc_pkg.sv ----
// Package: constants and types shared by the synthesizer core files.
// Assumes a 40 MHz core clock and plain control ports, no register bus.
package ddspc_pkg;
	localparam int          ACC_W          = 32;
	localparam int          PHASE_W        = 19;
	localparam int          AMP_W          = 10;
	localparam int          MULT_W         = 5;
	localparam logic [4:0]  MULT_MIN       = 5'h04;
	localparam logic [4:0]  MULT_MAX       = 5'h14;
	localparam logic [31:0] FTW_NYQUIST    = 32'h8000_0000;
	localparam int          LUT_ADDR_W     = 6;
	localparam int          RESET_MIN_CYC  = 5;
	localparam real         PLL_LOCK_MS    = 1.0;
	localparam real         CLK_NS         = 25.0;
	localparam int          PLL_LOCK_CYC   = int'(PLL_LOCK_MS * 1.0e6 / CLK_NS);
	localparam int          LOCK_CNT_W     = 16;
	localparam logic [15:0] LOCK_CNT_ZERO  = 16'h0000;
	localparam logic [15:0] LOCK_CNT_ONE   = 16'h0001;
	localparam logic [31:0] ACC_ZERO       = 32'h0000_0000;
	localparam logic [9:0]  AMP_MID        = 10'h200;
	localparam logic [2:0]  SYNC_DIV_LAST  = 3'h3;
	localparam logic [2:0]  SYNC_DIV_ZERO  = 3'h0;
	localparam logic [2:0]  SYNC_DIV_ONE   = 3'h1;

	typedef enum logic [1:0] {
		DDSPC_CLK_OFF  = 2'b00,
		DDSPC_CLK_REF  = 2'b01,
		DDSPC_CLK_MULT = 2'b10
	} ddspc_clk_mode_t;
endpackage : ddspc_pkg

// ---- ddspc_phase_if.sv ----
// Interface: phase word from the accumulator to the cosine converter.
// Assumes both ends run on the core clock.
interface ddspc_phase_if;
	import ddspc_pkg::*;
	logic [PHASE_W-1:0] phase;
	logic [AMP_W-1:0]   amp;
	modport acc (output phase, input amp);
	modport lut (input phase, output amp);
endinterface : ddspc_phase_if

// ---- ddspc_cos.sv ----
// Cosine phase-to-amplitude converter, offset binary for a 10-bit converter.
// Assumes the phase word on the interface is already truncated.
module ddspc_cos
	import ddspc_pkg::*;
(
	input  wire logic   i_mclk,    // Core clock
	input  wire logic   i_resetn,  // Synchronous reset, active low
	ddspc_phase_if.lut  p          // Phase in, amplitude out
);
	typedef struct packed {
		logic [AMP_W-1:0] amp;
	} ddspc_cos_state_t;

	ddspc_cos_state_t state;
	ddspc_cos_state_t next_state;

	// Quarter-wave table, 64 entries of cos over 0..pi/2, top magnitude 511
	function automatic logic [8:0] ddspc_quarter(input logic [LUT_ADDR_W-1:0] a);
		real x;
		x = 511.0 * $cos(3.14159265358979 * (real'(a) + 0.5) / 128.0);
		return 9'(int'(x));
	endfunction : ddspc_quarter

	logic [1:0]            quad;
	logic [LUT_ADDR_W-1:0] addr;
	logic [8:0]            mag;

	always_comb begin
		next_state = state;
		quad = p.phase[PHASE_W-1 -: 2];
		addr = p.phase[PHASE_W-3 -: LUT_ADDR_W];
		// Mirror the quarter table across the four quadrants
		mag  = (quad[0]) ? ddspc_quarter(~addr) : ddspc_quarter(addr);
		if (quad[1] ^ quad[0]) begin
			next_state.amp = AMP_MID - {1'b0, mag};
		end else begin
			next_state.amp = AMP_MID + {1'b0, mag};
		end
		if (!i_resetn) begin
			next_state.amp = AMP_MID;
		end
	end

	always_ff @(posedge i_mclk) begin
		state <= next_state;
	end

	assign p.amp = state.amp;
endmodule : ddspc_cos

// ---- ddspc_lock.sv ----
// Multiplier lock timer: busy after a multiplier change for the lock time.
// Assumes the multiplier field is on the core clock.
module ddspc_lock
	import ddspc_pkg::*;
#(
	parameter int LOCK_CYC = PLL_LOCK_CYC
) (
	input  wire logic              i_mclk,     // Core clock
	input  wire logic              i_resetn,   // Synchronous reset, active low
	input  wire logic [MULT_W-1:0] i_mult,     // Active multiplier field
	output logic                   o_locking   // Lock wait in progress
);
	typedef struct packed {
		logic [MULT_W-1:0]     last;
		logic [LOCK_CNT_W-1:0] cnt;
	} ddspc_lock_state_t;

	ddspc_lock_state_t state;
	ddspc_lock_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.last = i_mult;
		if (i_mult != state.last) begin
			next_state.cnt = LOCK_CNT_W'(LOCK_CYC);
		end else if (state.cnt != LOCK_CNT_ZERO) begin
			next_state.cnt = state.cnt - LOCK_CNT_ONE;
		end
		if (!i_resetn) begin
			next_state = '0;
		end
	end

	always_ff @(posedge i_mclk) begin
		state <= next_state;
	end

	assign o_locking = (state.cnt != LOCK_CNT_ZERO);
endmodule : ddspc_lock

// ---- ddspc_mcu_model.sv ----
// Serial controller model: sends one byte per frame, msb first, 200 ns clock.
// Assumes the bench raises i_go after a clock edge and waits on o_busy.
module ddspc_mcu_model (
	input  wire logic       i_go,    // Start a frame
	input  wire logic       i_sel,   // Select the device in the frame
	input  wire logic [7:0] i_byte,  // Byte to send
	input  wire logic       i_abort, // Abort pin level
	output logic            o_csn,   // Chip select, active low
	output logic            o_sclk,  // Serial clock, still between frames
	output logic            o_sdio,  // Data pin
	output logic            o_busy   // Frame running
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_csn = 1'b1;
		o_sclk = 1'b0;
		o_sdio = 1'b0;
		o_busy = 1'b0;
	end
	always @(posedge i_go) begin
		o_busy = 1'b1;
		o_csn = !i_sel;
		for (int b = 7; b >= 0 && !i_abort; b--) begin
			o_sdio = i_byte[b];
			#100 o_sclk = 1'b1;
			#100 o_sclk = 1'b0;
		end
		o_csn = 1'b1;
		// Released line shows no stale bit
		o_sdio = ~o_sdio;
		o_busy = 1'b0;
	end
endmodule : ddspc_mcu_model

// ---- ddspc_core_props.sv ----
// Checker: port-level relations of the synthesizer core.
// Assumes one core clock and a synchronous active-low reset.
module ddspc_core_props
	import ddspc_pkg::*;
#(
	parameter int LOCK_CYC = PLL_LOCK_CYC
) (
	input wire logic               i_mclk,              // Core clock
	input wire logic               i_resetn,            // Reset, active low
	input wire logic               i_hw_reset,          // Device reset pin
	input wire logic               i_osc_mode_select,   // Oscillator mode pin
	input wire logic               i_serial_port_abort, // Abort pin
	input wire logic               i_csn,               // Chip select
	input wire logic               i_three_wire,        // Data pin input only
	input wire logic               i_keying_en,         // Keying enabled
	input wire logic [AMP_W-1:0]   o_amp,               // Converter code
	input wire logic [PHASE_W-1:0] o_phase,             // Truncated phase
	input wire logic               o_osc_enable,        // Crystal running
	input wire logic               o_osc_buf_enable,    // Buffer on
	input wire logic               o_crystal_out_en,    // Crystal-out buffer
	input wire ddspc_clk_mode_t    o_clk_mode,          // Clock source
	input wire logic [MULT_W-1:0]  o_mult_factor,       // Multiplier
	input wire logic               o_pll_powerdown,     // Multiplier off
	input wire logic               o_serial_reset,      // Serial reset
	input wire logic               o_sclk_rise,         // Serial clock edge
	input wire logic               o_sdio_oen,          // Data pin enable
	input wire logic               o_serial_out_pin,    // Serial output
	input wire logic               o_keying_dir         // Keying direction
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	osc_on_a: assert property (i_osc_mode_select [*5] |-> o_osc_enable)
		else $error("oscillator not on");
	osc_off_a: assert property (!i_osc_mode_select [*5] |->
		!o_osc_enable && !o_osc_buf_enable && !o_crystal_out_en)
		else $error("oscillator not off");
	gate_keeps_xtal_a: assert property (o_clk_mode == DDSPC_CLK_OFF |->
		o_osc_enable && !o_osc_buf_enable) else $error("gated clock state wrong");
	buf_runs_clock_a: assert property (o_osc_buf_enable |-> o_clk_mode != DDSPC_CLK_OFF)
		else $error("clock off with buffer on");
	mult_range_a: assert property (o_clk_mode == DDSPC_CLK_MULT |-> !o_pll_powerdown &&
		o_mult_factor >= MULT_MIN && o_mult_factor <= MULT_MAX) else $error("bad factor");
	bypass_unity_a: assert property (o_clk_mode == DDSPC_CLK_REF |->
		o_mult_factor == 5'h01 && o_pll_powerdown) else $error("bypass wrong");
	abort_reset_a: assert property (i_serial_port_abort [*4] |->
		o_serial_reset && !o_sclk_rise) else $error("abort ignored");
	deselect_quiet_a: assert property (i_csn [*5] |-> !o_sclk_rise)
		else $error("clock edge while deselected");
	three_wire_a: assert property (i_three_wire |=> o_sdio_oen)
		else $error("data pin driven in three-wire");
	two_wire_a: assert property (!i_three_wire |=> !o_serial_out_pin)
		else $error("output pin used in two-wire");
	zero_phase_amp_a: assert property ((o_phase == '0 && !i_hw_reset) [*6] |=>
		o_amp == 10'h3ff) else $error("amplitude at zero phase wrong");
	keying_off_a: assert property (!i_keying_en [*3] |-> !o_keying_dir)
		else $error("keying direction while disabled");
endmodule : ddspc_core_props
bind ddspc_core ddspc_core_props #(.LOCK_CYC(LOCK_CYC)) u_ddspc_core_props (.*);

// ---- test_ddspc_core.sv ----
// Testbench: random and corner stimulus for the synthesizer core.
// Assumes the core, its checker and the serial controller model are compiled.
module test_ddspc_core
	import ddspc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk = 1'b0;
	logic i_resetn, i_hw_reset, i_clear_phase, i_buf_disable, i_osc_out_en, i_io_update;
	logic i_osc_mode_select, i_serial_port_abort, i_csn, i_sclk, i_sdio_in, i_three_wire;
	logic i_read_bit, i_read_active, i_keying_en, i_keying_direction_in, i_sync_in;
	logic [ACC_W-1:0]   i_freq_tuning_word;
	logic [MULT_W-1:0]  i_mult, o_mult_factor;
	logic [AMP_W-1:0]   o_amp;
	logic [PHASE_W-1:0] o_phase, ph;
	ddspc_clk_mode_t    o_clk_mode;
	logic o_osc_enable, o_osc_buf_enable, o_crystal_out_en, o_pll_powerdown, o_pll_locking;
	logic o_serial_reset, o_serial_enable, o_sclk_rise, o_sdi, o_sdio_out, o_sdio_oen;
	logic o_serial_out_pin, o_sync_clk, o_keying_dir, o_sync_edge, go, sel, busy;
	logic [7:0]  tx;
	logic [2:0]  r;
	logic [4:0]  mv [7] = '{5'h00, 5'h03, 5'h04, 5'h0c, 5'h14, 5'h15, 5'h1f};
	int          miscompares = 0, check_count = 0, seed = 32'hc8e1, n;

	ddspc_core #(.LOCK_CYC(20)) u_ddspc_core (.*);
	ddspc_mcu_model u_ddspc_mcu_model (.i_go(go), .i_sel(sel), .i_byte(tx),
		.i_abort(i_serial_port_abort), .o_csn(i_csn), .o_sclk(i_sclk), .o_sdio(i_sdio_in),
		.o_busy(busy));

	always #12.5 i_mclk = ~i_mclk;

	task automatic complete_run();
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : compare

	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask : cyc

	task automatic update(input logic [31:0] f, input logic c, input logic [4:0] m,
		input logic bd, input logic oo);
		i_freq_tuning_word = f;
		i_clear_phase = c;
		i_mult = m;
		i_buf_disable = bd;
		i_osc_out_en = oo;
		i_io_update = 1'b1;
		cyc(3);
		i_io_update = 1'b0;
		cyc(8);
	endtask : update

	task automatic steps(input logic [31:0] f);
		update(f, 1'b0, i_mult, i_buf_disable, i_osc_out_en);
		repeat (6) begin
			ph = o_phase;
			cyc(1);
			ph = o_phase - ph;
			compare(ph, f[31:13]);
		end
	endtask : steps

	function automatic ddspc_clk_mode_t exp_mode(input logic s, input logic bd,
		input logic [4:0] m);
		if (s && bd)
			return DDSPC_CLK_OFF;
		return (m >= MULT_MIN && m <= MULT_MAX) ? DDSPC_CLK_MULT : DDSPC_CLK_REF;
	endfunction : exp_mode

	task automatic frame(input logic s, input int abort_at);
		tx = 8'($random(seed));
		sel = s;
		go = 1'b1;
		n = 0;
		for (int t = 0; t < 400 && (t < 2 || busy); t++) begin
			r = 3'($random(seed));
			{i_three_wire, i_read_active, i_read_bit} = r;
			cyc(1);
			if (o_sclk_rise === 1'b1) begin
				if (n < 8)
					compare(o_sdi, tx[7 - n]);
				n++;
			end
			if (s && t > 8 && t < 56 && t < abort_at) begin
				compare(o_serial_enable, 1'b1);
				compare(o_sdio_oen, !(!r[2] && r[1]));
				compare(o_serial_out_pin, r[2] & r[0]);
				if (o_sdio_oen === 1'b0)
					compare(o_sdio_out, r[0]);
			end
			if (t == abort_at)
				i_serial_port_abort = 1'b1;
		end
		go = 1'b0;
		compare(busy, 1'b0);
		if (busy)
			complete_run();
		if (abort_at < 400)
			compare(n < 8 && o_serial_reset, 1'b1);
		else
			compare(n, s ? 8 : 0);
		cyc(2);
	endtask : frame

	initial begin
		repeat (20000) @(posedge i_mclk);
		miscompares++;
		complete_run();
	end

	initial begin
		{i_resetn, i_hw_reset, i_clear_phase, i_buf_disable, i_osc_out_en, i_io_update} = '0;
		{i_osc_mode_select, i_serial_port_abort, i_three_wire, i_read_bit} = '0;
		{i_read_active, i_keying_en, i_keying_direction_in, i_sync_in, go, sel} = '0;
		{i_freq_tuning_word, i_mult, tx} = '0;
		cyc(4);
		compare(o_amp, AMP_MID);
		compare({o_clk_mode, o_mult_factor, o_pll_powerdown}, {DDSPC_CLK_REF, 5'h01, 1'b1});
		i_resetn = 1'b1;
		i_freq_tuning_word = 32'h1234_e000;
		cyc(20);
		compare(o_phase, 19'h0);
		compare(o_amp, 10'h3ff);
		steps(32'h8000_0000);
		steps(32'hffff_e000);
		repeat (4) steps($random(seed) & 32'hffff_e000);
		update(32'h0, 1'b0, i_mult, 1'b0, 1'b0);
		ph = o_phase;
		cyc(10);
		compare(o_phase, ph);
		update(32'h0100_0000, 1'b1, i_mult, 1'b0, 1'b0);
		compare(o_phase, 19'h0);
		foreach (mv[k])
			for (int j = 0; j < 4; j++) begin
				i_osc_mode_select = j[1];
				update(i_freq_tuning_word, 1'b0, mv[k], j[0], 1'($random(seed)));
				compare(o_clk_mode, exp_mode(j[1], j[0], mv[k]));
				n = (exp_mode(1'b0, 1'b0, mv[k]) == DDSPC_CLK_MULT);
				compare(o_mult_factor, n ? mv[k] : 5'h01);
				compare(o_pll_powerdown, !n);
				compare({o_osc_enable, o_osc_buf_enable}, {j[1], j[1] & !j[0]});
				compare(o_crystal_out_en, j[1] & i_osc_out_en);
			end
		i_osc_mode_select = 1'b0;
		for (int t = 0; t < 100 && o_pll_locking; t++)
			cyc(1);
		compare(o_pll_locking, 1'b0);
		frame(1'b1, 999);
		frame(1'b0, 999);
		frame(1'b1, 10);
		i_serial_port_abort = 1'b0;
		cyc(4);
		frame(1'b1, 999);
		i_keying_en = 1'b1;
		i_keying_direction_in = 1'b1;
		cyc(24);
		compare(o_keying_dir, 1'b1);
		i_sync_in = 1'b1;
		n = 0;
		repeat (8) begin
			cyc(1);
			if (o_sync_edge === 1'b1)
				n++;
		end
		compare(n, 1);
		update(32'h0200_0000, 1'b0, 5'h08, 1'b0, 1'b0);
		compare(o_pll_locking, 1'b1);
		i_hw_reset = 1'b1;
		cyc(6);
		i_hw_reset = 1'b0;
		cyc(8);
		compare({o_phase, o_clk_mode, o_mult_factor}, {19'h0, DDSPC_CLK_REF, 5'h01});
		complete_run();
	end
endmodule : test_ddspc_core
